/* logic/oml_decode.sv */
// Field decoder for the two option bytes.
`timescale 1ns/10ps
module oml_decode
  import oml_pkg::*;
(
  input wire logic [7:0] pri,
  input wire logic [7:0] sec,
  output oml_opt_t opt
);

  always_comb begin
    opt.autostart = ~pri[OML_B_AUTOSTART];
    opt.count_protect = ~pri[OML_B_CSP];
    opt.vmon0_reset_en = ~pri[OML_B_VMON0];
    // Only one of the four codes arms protection, so a half-written
    // byte fails open rather than locking the part.
    opt.code_protect_en =
      ({pri[OML_B_PROT_ON], pri[OML_B_PROT_OVR]} == OML_PROT_ACTIVE);
    case ({sec[OML_B_UF_HI], sec[OML_B_UF_LO]})
      2'h0: opt.underflow_cnt = OML_UF_CNT0;
      2'h1: opt.underflow_cnt = OML_UF_CNT1;
      2'h2: opt.underflow_cnt = OML_UF_CNT2;
      default: opt.underflow_cnt = OML_UF_CNT3;
    endcase
    opt.win_sel = {sec[OML_B_WIN_HI], sec[OML_B_WIN_LO]};
  end

endmodule : oml_decode

/* logic/oml_loader.sv */
// Option byte loader: fetches, decodes and publishes reset configuration.
`timescale 1ns/10ps
module oml_loader
  import oml_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [15:0] flash_addr,
  output logic flash_rd,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_blank,
  output logic cfg_valid,
  output oml_cfg_t cfg_out
);

  // ==========================================================================
  // State and helpers
  oml_state_t st_reg;
  oml_state_t st_next;
  oml_opt_t opt;
  logic [OML_CNT_W-1:0] limit;
  logic ctrl_wr;
  logic [7:0] fetched;

  oml_decode u_decode (
    .pri(st_reg.pri),
    .sec(st_reg.sec),
    .opt(opt)
  );

  oml_window u_window (
    .underflow_cnt(opt.underflow_cnt),
    .win_sel(opt.win_sel),
    .refresh_limit(limit)
  );

  assign ctrl_wr = reg_wr && (reg_addr == OML_CTRL_ADDR);
  // A block erase leaves the cells at all ones whatever the array returns.
  assign fetched = flash_blank ? OML_BLANK : flash_rdata;

  // ==========================================================================
  // Fetch sequence and register port
  always_comb begin
    st_next = st_reg;
    st_next.flash_rd = 1'b0;
    st_next.rdata = 16'h0000;
    case (st_reg.fsm)
      OML_ST_RD_PRI: begin
        st_next.valid = 1'b0;
        st_next.flash_rd = 1'b1;
        st_next.flash_addr = OML_PRI_ADDR;
        st_next.fsm = OML_ST_WT_PRI;
      end
      OML_ST_WT_PRI: begin
        st_next.fsm = OML_ST_CAP_PRI;
      end
      OML_ST_CAP_PRI: begin
        st_next.pri = fetched;
        st_next.pri_blank = flash_blank;
        st_next.flash_rd = 1'b1;
        st_next.flash_addr = OML_SEC_ADDR;
        st_next.fsm = OML_ST_WT_SEC;
      end
      OML_ST_WT_SEC: begin
        st_next.fsm = OML_ST_CAP_SEC;
      end
      OML_ST_CAP_SEC: begin
        st_next.sec = fetched;
        st_next.sec_blank = flash_blank;
        st_next.fsm = OML_ST_APPLY;
      end
      OML_ST_APPLY: begin
        st_next.cfg.count_protect = opt.count_protect;
        st_next.cfg.vmon0_reset_en = opt.vmon0_reset_en;
        st_next.cfg.code_protect_en = opt.code_protect_en;
        st_next.cfg.underflow_cnt = opt.underflow_cnt;
        st_next.cfg.refresh_limit = limit;
        st_next.valid = 1'b1;
        st_next.fsm = OML_ST_DONE;
      end
      OML_ST_DONE: begin
        // Reload repeats the reset-time fetch; the old settings stay on
        // the outputs meanwhile, but the watchdog is held until it ends.
        if (ctrl_wr && reg_wdata[OML_C_RELOAD]) begin
          st_next.fsm = OML_ST_RD_PRI;
        end
      end
      default: begin
        st_next.fsm = OML_ST_RD_PRI;
      end
    endcase

    // Software start is set-only; only reset clears it, and a reload stops the watchdog until it ends.
    if (ctrl_wr && reg_wdata[OML_C_START]) begin
      st_next.sw_start = 1'b1;
    end
    st_next.cfg.run = st_next.valid &&
      (opt.autostart || st_next.sw_start);

    if (reg_rd) begin
      case (reg_addr)
        OML_PRI_ADDR: st_next.rdata = {8'h00, st_reg.pri};
        OML_SEC_ADDR: st_next.rdata = {8'h00, st_reg.sec};
        OML_CTRL_ADDR: st_next.rdata = {14'h0000, st_reg.sw_start, 1'b0};
        OML_STAT_ADDR: st_next.rdata = {12'h000, st_reg.cfg.run,
          st_reg.sec_blank, st_reg.pri_blank, st_reg.valid};
        OML_UFCNT_ADDR: st_next.rdata = {2'h0, st_reg.cfg.underflow_cnt};
        OML_WIN_ADDR: st_next.rdata = {2'h0, st_reg.cfg.refresh_limit};
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= OML_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = st_reg.rdata;
  assign flash_addr = st_reg.flash_addr;
  assign flash_rd = st_reg.flash_rd;
  assign cfg_valid = st_reg.valid;
  assign cfg_out = st_reg.cfg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_pri_fetch;
    (st_reg.fsm == OML_ST_RD_PRI) ##1
      (flash_rd && flash_addr == OML_PRI_ADDR);
  endsequence

  sequence seq_sec_fetch;
    (st_reg.fsm == OML_ST_CAP_PRI) ##1
      (flash_rd && flash_addr == OML_SEC_ADDR);
  endsequence

  a_fetch_order: assert property (
    seq_pri_fetch |-> ##1 seq_sec_fetch)
    else $error("option bytes not fetched in order from fixed addresses");

  a_load_done: assert property (
    (st_reg.fsm == OML_ST_RD_PRI) |-> ##6 cfg_valid)
    else $error("configuration not valid six cycles after fetch start");

  a_wdog_start: assert property (
    cfg_valid && !st_reg.pri[OML_B_AUTOSTART] |-> cfg_out.run)
    else $error("watchdog not running with auto start selected");

  a_wdog_halt: assert property (
    cfg_valid && st_reg.pri[OML_B_AUTOSTART] && !st_reg.sw_start
      |-> !cfg_out.run)
    else $error("watchdog running without auto start or software start");

  a_code_protect: assert property (
    cfg_valid |-> cfg_out.code_protect_en ==
      (!st_reg.pri[OML_B_PROT_ON] && st_reg.pri[OML_B_PROT_OVR]))
    else $error("code protection does not follow bits 3 and 2");

  a_vmon0_sel: assert property (
    cfg_valid |-> cfg_out.vmon0_reset_en == !st_reg.pri[OML_B_VMON0])
    else $error("voltage monitor 0 reset enable does not follow bit 6");

  a_count_protect: assert property (
    cfg_valid |-> cfg_out.count_protect == !st_reg.pri[OML_B_CSP])
    else $error("count source protection does not follow bit 7");

  a_uf_period: assert property (
    cfg_valid |-> cfg_out.underflow_cnt ==
      ((st_reg.sec[1:0] == 2'h0) ? 14'h03FF :
       (st_reg.sec[1:0] == 2'h1) ? 14'h0FFF :
       (st_reg.sec[1:0] == 2'h2) ? 14'h1FFF : 14'h3FFF))
    else $error("underflow count does not match bits 1 and 0");

  a_win_quarter: assert property (
    cfg_valid && st_reg.sec[3:2] == 2'h0 |->
      cfg_out.refresh_limit == (cfg_out.underflow_cnt >> 2))
    else $error("25 percent window limit wrong");

  a_win_full: assert property (
    cfg_valid && st_reg.sec[3:2] == 2'h3 |->
      cfg_out.refresh_limit == cfg_out.underflow_cnt)
    else $error("100 percent window limit is not the whole span");

  a_erased_ones: assert property (
    (st_reg.fsm == OML_ST_CAP_PRI) && flash_blank |=>
      st_reg.pri == 8'hFF && st_reg.pri_blank)
    else $error("erased primary option byte not read as all ones");

  a_read_slot: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data present outside the slot after a read");

endmodule : oml_loader

/* logic/oml_pkg.sv */
// Constants and types for the option byte configuration loader.
package oml_pkg;

  // ==========================================================================
  // Addresses
  localparam logic [15:0] OML_PRI_ADDR = 16'hFFFF;
  localparam logic [15:0] OML_SEC_ADDR = 16'hFFDB;
  localparam logic [15:0] OML_CTRL_ADDR = 16'h0000;
  localparam logic [15:0] OML_STAT_ADDR = 16'h0004;
  localparam logic [15:0] OML_UFCNT_ADDR = 16'h0008;
  localparam logic [15:0] OML_WIN_ADDR = 16'h000C;

  // ==========================================================================
  // Field positions
  localparam int OML_B_AUTOSTART = 0;
  localparam int OML_B_PROT_OVR = 2;
  localparam int OML_B_PROT_ON = 3;
  localparam int OML_B_VMON0 = 6;
  localparam int OML_B_CSP = 7;
  localparam int OML_B_UF_LO = 0;
  localparam int OML_B_UF_HI = 1;
  localparam int OML_B_WIN_LO = 2;
  localparam int OML_B_WIN_HI = 3;
  localparam int OML_C_RELOAD = 0;
  localparam int OML_C_START = 1;
  localparam int OML_S_VALID = 0;
  localparam int OML_S_PRI_BLANK = 1;
  localparam int OML_S_SEC_BLANK = 2;
  localparam int OML_S_RUN = 3;

  // ==========================================================================
  // Values
  localparam int OML_CNT_W = 14;
  localparam logic [7:0] OML_BLANK = 8'hFF;
  localparam logic [1:0] OML_PROT_ACTIVE = 2'h1;
  localparam logic [13:0] OML_UF_CNT0 = 14'h03FF;
  localparam logic [13:0] OML_UF_CNT1 = 14'h0FFF;
  localparam logic [13:0] OML_UF_CNT2 = 14'h1FFF;
  localparam logic [13:0] OML_UF_CNT3 = 14'h3FFF;

  typedef enum logic [6:0] {
    OML_ST_RD_PRI = 7'h01,
    OML_ST_WT_PRI = 7'h02,
    OML_ST_CAP_PRI = 7'h04,
    OML_ST_WT_SEC = 7'h08,
    OML_ST_CAP_SEC = 7'h10,
    OML_ST_APPLY = 7'h20,
    OML_ST_DONE = 7'h40
  } oml_fsm_t;

  typedef struct packed {
    logic autostart;
    logic count_protect;
    logic vmon0_reset_en;
    logic code_protect_en;
    logic [OML_CNT_W-1:0] underflow_cnt;
    logic [1:0] win_sel;
  } oml_opt_t;

  typedef struct packed {
    logic run;
    logic count_protect;
    logic vmon0_reset_en;
    logic code_protect_en;
    logic [OML_CNT_W-1:0] underflow_cnt;
    logic [OML_CNT_W-1:0] refresh_limit;
  } oml_cfg_t;

  typedef struct packed {
    oml_fsm_t fsm;
    logic [7:0] pri;
    logic [7:0] sec;
    logic pri_blank;
    logic sec_blank;
    logic valid;
    logic sw_start;
    logic [15:0] flash_addr;
    logic flash_rd;
    logic [15:0] rdata;
    oml_cfg_t cfg;
  } oml_state_t;

  // Erased-flash decode: watchdog stopped, every protection off.
  localparam oml_cfg_t OML_CFG_RST = '{run: 1'b0, count_protect: 1'b0,
    vmon0_reset_en: 1'b0, code_protect_en: 1'b0,
    underflow_cnt: OML_UF_CNT3, refresh_limit: OML_UF_CNT3};

  localparam oml_state_t OML_STATE_RST = '{fsm: OML_ST_RD_PRI,
    pri: OML_BLANK, sec: OML_BLANK, pri_blank: 1'b0, sec_blank: 1'b0,
    valid: 1'b0, sw_start: 1'b0, flash_addr: OML_PRI_ADDR,
    flash_rd: 1'b0, rdata: 16'h0000, cfg: OML_CFG_RST};

endpackage : oml_pkg

/* logic/oml_window.sv */
// Refresh window limit from the underflow count and the window choice.
`timescale 1ns/10ps
module oml_window
  import oml_pkg::*;
(
  input wire logic [OML_CNT_W-1:0] underflow_cnt,
  input wire logic [1:0] win_sel,
  output logic [OML_CNT_W-1:0] refresh_limit
);

  logic [16:0] span;
  logic [16:0] prod;
  logic [16:0] quarter;

  // The span runs from count start to underflow and counts as 100 percent.
  // The limit is the highest down-count value at which a refresh is taken.
  always_comb begin
    span = {3'h0, underflow_cnt} + 17'h00001;
    prod = 17'((span * ({15'h0000, win_sel} + 17'h00001)));
    quarter = prod >> 2;
    refresh_limit = OML_CNT_W'(quarter - 17'h00001);
  end

endmodule : oml_window

/* verif/oml_flash_model.sv */
// Flash array model that answers the loader's option byte fetches.
`timescale 1ns/10ps
module oml_flash_model
  import oml_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] flash_addr,
  input wire logic flash_rd,
  input wire logic [7:0] pri_byte,
  input wire logic [7:0] sec_byte,
  input wire logic pri_erased,
  input wire logic sec_erased,
  output logic [7:0] flash_rdata,
  output logic flash_blank
);
  logic [7:0] last_q = 8'h00;
  logic er;

  initial flash_rdata = 8'h00;
  initial flash_blank = 1'b0;

  // ==========================================================================
  // Answer path
  always @(posedge clk) begin
    er = (flash_addr == 16'hFFFF) ? pri_erased : sec_erased;
    if (flash_rd) begin
      // An erased block reads as all ones whatever was stored before.
      last_q = er ? 8'hFF : (flash_addr == 16'hFFFF) ? pri_byte : sec_byte;
      flash_rdata <= last_q;
      flash_blank <= er;
    end else begin
      // Data is only held for one cycle, so a late sample sees garbage.
      flash_rdata <= ~last_q;
      flash_blank <= 1'b0;
    end
  end
endmodule : oml_flash_model

/* verif/oml_loader_tb.sv */
// Self-checking testbench for the option byte loader.
`timescale 1ns/10ps
module oml_loader_tb;
  import oml_pkg::*;
  typedef struct packed {
    logic [7:0] p;
    logic [7:0] s;
    logic pe;
    logic se;
  } oml_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] flash_addr;
  logic flash_rd;
  logic [7:0] flash_rdata;
  logic flash_blank;
  logic cfg_valid;
  oml_cfg_t cfg_out;
  oml_row_t cur = '0;
  oml_cfg_t e;
  logic [15:0] d;
  logic [15:0] q [$];
  int n;
  int num_errors = 0;
  int comparisons = 0;
  logic [13:0] uf_tab [4] = '{14'h03FF, 14'h0FFF, 14'h1FFF, 14'h3FFF};
  // Reserved bits kept at their required levels in every programmed byte.
  oml_row_t rows [5] = '{'{8'h12, 8'hF0, 1'b0, 1'b0},
    '{8'h16, 8'hF5, 1'b0, 1'b0}, '{8'hDB, 8'hFA, 1'b0, 1'b0},
    '{8'h1E, 8'hFF, 1'b0, 1'b0}, '{8'h00, 8'h00, 1'b1, 1'b1}};

  always #50 clk = ~clk;

  oml_loader DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .flash_blank(flash_blank),
    .cfg_valid(cfg_valid), .cfg_out(cfg_out));

  oml_flash_model flash (.clk(clk), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .pri_byte(cur.p), .sec_byte(cur.s),
    .pri_erased(cur.pe), .sec_erased(cur.se), .flash_rdata(flash_rdata),
    .flash_blank(flash_blank));

  // ==========================================================================
  // Helpers
  function automatic oml_cfg_t exp_cfg(input oml_row_t r, input logic st);
    logic [7:0] p;
    logic [7:0] s;
    oml_cfg_t c;
    p = r.pe ? 8'hFF : r.p;
    s = r.se ? 8'hFF : r.s;
    c.run = ~p[0] | st;
    c.count_protect = ~p[7];
    c.vmon0_reset_en = ~p[6];
    c.code_protect_en = (p[3:2] == 2'b01);
    c.underflow_cnt = uf_tab[s[1:0]];
    c.refresh_limit = 14'(((c.underflow_cnt + 1) * (s[3:2] + 1)) / 4 - 1);
    return c;
  endfunction : exp_cfg

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic wait_v(input logic lvl);
    n = 0;
    while (cfg_valid !== lvl && n < 20) begin
      @(negedge clk);
      n++;
      if (flash_rd === 1'b1) q.push_back(flash_addr);
    end
  endtask : wait_v

  // Each new content is applied while reset is held, then the fetch is checked.
  task automatic load(input oml_row_t r);
    @(posedge clk);
    rst <= 1'b1;
    cur <= r;
    @(negedge clk);
    chk({flash_rd, cfg_valid, flash_addr}, {2'b00, 16'hFFFF});
    chk(cfg_out, OML_CFG_RST);
    @(posedge clk);
    rst <= 1'b0;
    q = {};
    wait_v(1'b1);
    chk(n, 7);
    chk({q[0], q[1]}, {16'hFFFF, 16'hFFDB});
  endtask : load

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Watchdog
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      load(rows[i]);
      e = exp_cfg(rows[i], 1'b0);
      chk(cfg_out, e);
      rd(OML_PRI_ADDR, d);
      chk(d, {8'h00, rows[i].pe ? 8'hFF : rows[i].p});
      rd(OML_SEC_ADDR, d);
      chk(d, {8'h00, rows[i].se ? 8'hFF : rows[i].s});
      rd(OML_STAT_ADDR, d);
      chk(d, {12'h000, e.run, rows[i].se, rows[i].pe, 1'b1});
      rd(OML_UFCNT_ADDR, d);
      chk(d, {2'b00, e.underflow_cnt});
      rd(OML_WIN_ADDR, d);
      chk(d, {2'b00, e.refresh_limit});
    end
    load(rows[2]);
    chk(cfg_out.run, 1'b0);
    wr(OML_CTRL_ADDR, 16'h0002);
    @(negedge clk);
    chk(cfg_out.run, 1'b1);
    rd(OML_CTRL_ADDR, d);
    chk(d[1], 1'b1);
    wr(OML_PRI_ADDR, 16'h0000);
    rd(OML_PRI_ADDR, d);
    chk(d, 16'h00DB);
    rd(16'h0010, d);
    chk(d, 16'h0000);
    @(negedge clk);
    chk(reg_rdata, 16'h0000);
    cur <= rows[1];
    wr(OML_CTRL_ADDR, 16'h0001);
    wait_v(1'b0);
    chk(cfg_out.run, 1'b0);
    wait_v(1'b1);
    chk(cfg_out, exp_cfg(rows[1], 1'b1));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(flash_rd, 1'b0);
    @(negedge clk);
    chk({flash_rd, flash_addr}, {1'b1, OML_PRI_ADDR});
    load(rows[2]);
    chk(cfg_out, exp_cfg(rows[2], 1'b0));
    end_of_test;
  end
endmodule : oml_loader_tb
